/* File: ppcsb_consts.svh */
// Address map, field positions and reset values of the port/PHY register bank.
// Assumes it is included by its bare name before the bank's code.
`ifndef PPCSB_CONSTS_SVH
`define PPCSB_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define PPCSB_OFS_PORT1_CTRL 4'h0
`define PPCSB_OFS_CABLE_DIAG 4'h4
`define PPCSB_OFS_PHY_SPECIAL 4'h6

// ---------------------------------------------------------------
// Cable diagnostic register fields
// ---------------------------------------------------------------
`define PPCSB_DIAG_START 15
`define PPCSB_DIAG_RES_HI 14
`define PPCSB_DIAG_RES_LO 13
`define PPCSB_DIAG_NEAR 12
`define PPCSB_DIAG_CNT_HI 8
`define PPCSB_DIAG_CNT_LO 0

// ---------------------------------------------------------------
// PHY special control/status fields
// ---------------------------------------------------------------
`define PPCSB_SPC_POL 5
`define PPCSB_SPC_XOVER 4
`define PPCSB_SPC_FORCE 3
`define PPCSB_SPC_PWR 2
`define PPCSB_SPC_RLB 1

// ---------------------------------------------------------------
// Port one control fields
// ---------------------------------------------------------------
`define PPCSB_P1_STORM 7
`define PPCSB_P1_DSCP 6
`define PPCSB_P1_DOT1P 5
`define PPCSB_P1_PRIO_HI 4
`define PPCSB_P1_PRIO_LO 3
`define PPCSB_P1_TAGINS 2
`define PPCSB_P1_TAGRM 1
`define PPCSB_P1_MULTIQ 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PPCSB_RST_OFF 1'b0
`define PPCSB_RST_PWR 1'b1
`define PPCSB_RST_PRIO 2'h0
`define PPCSB_RST_CNT 9'h000
`define PPCSB_RST_DATA 16'h0000

`endif

/* File: ppcsb_pkg.sv */
// Types shared by the port/PHY register bank and its surroundings.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package ppcsb_pkg;

	typedef enum logic [1:0] {
		RES_NORMAL = 2'h0,
		RES_OPEN = 2'h1,
		RES_SHORT = 2'h2,
		RES_FAILED = 2'h3
	} ppcsb_result_e;

	typedef logic [8:0] ppcsb_count_t;
	typedef logic [1:0] ppcsb_queue_t;

	// Finished diagnostic from the second PHY
	typedef struct packed {
		logic done;
		ppcsb_result_e result;
		logic nearShort;
		ppcsb_count_t faultCount;
	} ppcsb_diag_s;

	typedef struct packed {
		logic polarityReversed;
		logic crossoverState;
		logic linkDetected;
	} ppcsb_phy_status_s;

	typedef struct packed {
		logic linkPass;
		logic powerSaveDisable;
		logic remoteLoopback;
	} ppcsb_phy_ctrl_s;

	typedef struct packed {
		logic valid;
		logic dscpHit;
		ppcsb_queue_t dscpPrio;
		logic dot1pHit;
		ppcsb_queue_t dot1pPrio;
	} ppcsb_ingress_s;

	typedef struct packed {
		logic valid;
		ppcsb_queue_t queue;
	} ppcsb_class_s;

	typedef struct packed {
		logic valid;
		logic arrivedTagged;
	} ppcsb_egress_s;

	typedef struct packed {
		logic valid;
		logic addTag;
		logic stripTag;
	} ppcsb_egress_act_s;

endpackage

`default_nettype wire

/* File: ppcsb_bank.sv */
// Register bank for the second PHY's cable diagnostic and special control,
// plus port one ingress classification and egress tag handling.
// Assumes a register master on a plain strobe port and a PHY and switch
// fabric on the same clock and reset.
`default_nettype none

`include "ppcsb_consts.svh"

// How it works
// - Writing one to the start bit launches a cable test that the bank clears itself when the PHY reports done, and zero means results are valid.
// - The two-bit outcome reads 00 normal, 01 open, 10 short and 11 test failed.
// - A status bit reads one when the test found a short closer than ten metres.
// - A nine-bit count holds the distance to the fault at about 0.4 metre per count.
// - A status bit reads one while the second PHY sees reversed receive polarity.
// - A status bit reads one for straight MDI and zero for crossed MDIX.
// - The force-link bit makes the second PHY's link pass whatever detection says.
// - The power-saving bit is inverted, one disables saving, and it resets to one.
// - The remote loopback bit turns the PHY's receive pair back onto its transmit pair.
// - An enable bit switches broadcast storm protection for port one ingress.
// - An enable bit lets DiffServ code points classify port one ingress priority.
// - An enable bit lets 802.1p user priority classify port one ingress priority.
// - A two-bit default priority picks queue 0 to 3 when no other class applies.
// - Enabled DiffServ and 802.1p results are ORed and override the default priority.
// - Tag insertion adds a tag with the port VID only to egress packets that came in untagged.
// - Tag removal strips the tag only from egress packets that came in tagged.
module ppcsb_bank #(
	parameter int ADDR_W = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Register port
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdata,
	// Second PHY diagnostic
	output logic cableTestStart,
	input wire ppcsb_pkg::ppcsb_diag_s diagIn,
	// Second PHY status and control
	input wire ppcsb_pkg::ppcsb_phy_status_s phyStatus,
	output ppcsb_pkg::ppcsb_phy_ctrl_s phyCtrl,
	// Port one fabric settings
	output logic stormProtectEn,
	output logic multiQueueEn,
	input wire ppcsb_pkg::ppcsb_ingress_s ingressIn,
	output ppcsb_pkg::ppcsb_class_s classOut,
	input wire ppcsb_pkg::ppcsb_egress_s egressIn,
	output ppcsb_pkg::ppcsb_egress_act_s egressOut
);
	import ppcsb_pkg::*;

	// ---------------------------------------------------------------
	// Elaboration check
	// ---------------------------------------------------------------
	if (ADDR_W < 3) begin : g_bad_addr
		$error("ADDR_W too narrow for the register offsets");
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	wire logic selPort1 = (regAddr == ADDR_W'(`PPCSB_OFS_PORT1_CTRL));
	wire logic selDiag = (regAddr == ADDR_W'(`PPCSB_OFS_CABLE_DIAG));
	wire logic selSpecial = (regAddr == ADDR_W'(`PPCSB_OFS_PHY_SPECIAL));
	wire logic wrPort1 = regWrite && selPort1;
	wire logic wrDiag = regWrite && selDiag;
	wire logic wrSpecial = regWrite && selSpecial;

	// ---------------------------------------------------------------
	// Cable diagnostic sequencer
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		DIAG_IDLE = 2'b01,
		DIAG_RUN = 2'b10
	} ppcsb_diag_state_e;

	ppcsb_diag_state_e diagState_reg, diagState_next;
	ppcsb_result_e result_reg;
	logic nearShort_reg;
	ppcsb_count_t faultCount_reg;
	logic cableTestStart_reg;

	// Start only from idle; a second write mid-test would confuse the PHY
	wire logic startReq = wrDiag && regWdata[`PPCSB_DIAG_START] &&
		(diagState_reg == DIAG_IDLE);
	wire logic testDone = diagIn.done && (diagState_reg == DIAG_RUN);

	always_comb begin
		diagState_next = diagState_reg;
		unique case (diagState_reg)
			DIAG_IDLE: begin
				if (startReq) begin
					diagState_next = DIAG_RUN;
				end
			end
			DIAG_RUN: begin
				if (diagIn.done) begin
					diagState_next = DIAG_IDLE;
				end
			end
			default: begin
				diagState_next = DIAG_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			diagState_reg <= DIAG_IDLE;
			cableTestStart_reg <= `PPCSB_RST_OFF;
		end else begin
			diagState_reg <= diagState_next;
			cableTestStart_reg <= startReq;
		end
	end

	// Results held until the next finished test
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_reg <= RES_NORMAL;
			nearShort_reg <= `PPCSB_RST_OFF;
			faultCount_reg <= `PPCSB_RST_CNT;
		end else if (testDone) begin
			result_reg <= diagIn.result;
			nearShort_reg <= diagIn.nearShort;
			faultCount_reg <= diagIn.faultCount;
		end
	end

	// ---------------------------------------------------------------
	// PHY special control
	// ---------------------------------------------------------------
	logic forceLink_reg;
	logic pwrSaveOff_reg;
	logic remoteLoop_reg;
	ppcsb_phy_ctrl_s phyCtrl_reg;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			forceLink_reg <= `PPCSB_RST_OFF;
			pwrSaveOff_reg <= `PPCSB_RST_PWR;
			remoteLoop_reg <= `PPCSB_RST_OFF;
		end else if (wrSpecial) begin
			forceLink_reg <= regWdata[`PPCSB_SPC_FORCE];
			pwrSaveOff_reg <= regWdata[`PPCSB_SPC_PWR];
			remoteLoop_reg <= regWdata[`PPCSB_SPC_RLB];
		end
	end

	// Outputs lag the control bits by one cycle to stay registered
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			phyCtrl_reg.linkPass <= `PPCSB_RST_OFF;
			phyCtrl_reg.powerSaveDisable <= `PPCSB_RST_PWR;
			phyCtrl_reg.remoteLoopback <= `PPCSB_RST_OFF;
		end else begin
			phyCtrl_reg.linkPass <= forceLink_reg ||
				phyStatus.linkDetected;
			phyCtrl_reg.powerSaveDisable <= pwrSaveOff_reg;
			phyCtrl_reg.remoteLoopback <= remoteLoop_reg;
		end
	end

	// ---------------------------------------------------------------
	// Port one control
	// ---------------------------------------------------------------
	logic storm_reg;
	logic dscpEn_reg;
	logic dot1pEn_reg;
	ppcsb_queue_t portPrio_reg;
	logic tagIns_reg;
	logic tagRm_reg;
	logic multiQ_reg;
	logic stormOut_reg;
	logic multiQOut_reg;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			storm_reg <= `PPCSB_RST_OFF;
			dscpEn_reg <= `PPCSB_RST_OFF;
			dot1pEn_reg <= `PPCSB_RST_OFF;
			portPrio_reg <= `PPCSB_RST_PRIO;
			tagIns_reg <= `PPCSB_RST_OFF;
			tagRm_reg <= `PPCSB_RST_OFF;
			multiQ_reg <= `PPCSB_RST_OFF;
		end else if (wrPort1) begin
			storm_reg <= regWdata[`PPCSB_P1_STORM];
			dscpEn_reg <= regWdata[`PPCSB_P1_DSCP];
			dot1pEn_reg <= regWdata[`PPCSB_P1_DOT1P];
			portPrio_reg <=
				regWdata[`PPCSB_P1_PRIO_HI:`PPCSB_P1_PRIO_LO];
			tagIns_reg <= regWdata[`PPCSB_P1_TAGINS];
			tagRm_reg <= regWdata[`PPCSB_P1_TAGRM];
			multiQ_reg <= regWdata[`PPCSB_P1_MULTIQ];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stormOut_reg <= `PPCSB_RST_OFF;
			multiQOut_reg <= `PPCSB_RST_OFF;
		end else begin
			stormOut_reg <= storm_reg;
			multiQOut_reg <= multiQ_reg;
		end
	end

	// ---------------------------------------------------------------
	// Ingress priority classification
	// ---------------------------------------------------------------
	wire logic dscpUse = dscpEn_reg && ingressIn.dscpHit;
	wire logic dot1pUse = dot1pEn_reg && ingressIn.dot1pHit;
	wire ppcsb_queue_t dscpPart = dscpUse ? ingressIn.dscpPrio : '0;
	wire ppcsb_queue_t dot1pPart = dot1pUse ? ingressIn.dot1pPrio : '0;
	// A classified packet ignores the port default entirely
	wire ppcsb_queue_t queueSel = (dscpUse || dot1pUse) ?
		(dscpPart | dot1pPart) : portPrio_reg;
	ppcsb_class_s class_reg;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			class_reg <= '0;
		end else begin
			class_reg.valid <= ingressIn.valid;
			class_reg.queue <= queueSel;
		end
	end

	// ---------------------------------------------------------------
	// Egress tag handling
	// ---------------------------------------------------------------
	ppcsb_egress_act_s egress_reg;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			egress_reg <= '0;
		end else begin
			egress_reg.valid <= egressIn.valid;
			egress_reg.addTag <= egressIn.valid && tagIns_reg &&
				!egressIn.arrivedTagged;
			egress_reg.stripTag <= egressIn.valid && tagRm_reg &&
				egressIn.arrivedTagged;
		end
	end

	// ---------------------------------------------------------------
	// Read images and read data
	// ---------------------------------------------------------------
	logic [15:0] diagImage;
	logic [15:0] specialImage;
	logic [15:0] port1Image;
	logic [15:0] regRdata_reg;

	// Unlisted bits stay at the zero fill
	always_comb begin
		diagImage = `PPCSB_RST_DATA;
		diagImage[`PPCSB_DIAG_START] = (diagState_reg == DIAG_RUN);
		diagImage[`PPCSB_DIAG_RES_HI:`PPCSB_DIAG_RES_LO] = result_reg;
		diagImage[`PPCSB_DIAG_NEAR] = nearShort_reg;
		diagImage[`PPCSB_DIAG_CNT_HI:`PPCSB_DIAG_CNT_LO] = faultCount_reg;
	end

	always_comb begin
		specialImage = `PPCSB_RST_DATA;
		specialImage[`PPCSB_SPC_POL] = phyStatus.polarityReversed;
		specialImage[`PPCSB_SPC_XOVER] = phyStatus.crossoverState;
		specialImage[`PPCSB_SPC_FORCE] = forceLink_reg;
		specialImage[`PPCSB_SPC_PWR] = pwrSaveOff_reg;
		specialImage[`PPCSB_SPC_RLB] = remoteLoop_reg;
	end

	always_comb begin
		port1Image = `PPCSB_RST_DATA;
		port1Image[`PPCSB_P1_STORM] = storm_reg;
		port1Image[`PPCSB_P1_DSCP] = dscpEn_reg;
		port1Image[`PPCSB_P1_DOT1P] = dot1pEn_reg;
		port1Image[`PPCSB_P1_PRIO_HI:`PPCSB_P1_PRIO_LO] = portPrio_reg;
		port1Image[`PPCSB_P1_TAGINS] = tagIns_reg;
		port1Image[`PPCSB_P1_TAGRM] = tagRm_reg;
		port1Image[`PPCSB_P1_MULTIQ] = multiQ_reg;
	end

	// Unmapped offsets read as zero
	wire logic [15:0] readSel = selDiag ? diagImage :
		selSpecial ? specialImage :
		selPort1 ? port1Image : `PPCSB_RST_DATA;

	// Data stands for the one cycle after the strobe only
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdata_reg <= `PPCSB_RST_DATA;
		end else begin
			regRdata_reg <= regRead ? readSel : `PPCSB_RST_DATA;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign regRdata = regRdata_reg;
	assign cableTestStart = cableTestStart_reg;
	assign phyCtrl = phyCtrl_reg;
	assign stormProtectEn = stormOut_reg;
	assign multiQueueEn = multiQOut_reg;
	assign classOut = class_reg;
	assign egressOut = egress_reg;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cbChk @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence sStartWrite;
		wrDiag && regWdata[`PPCSB_DIAG_START] && (diagState_reg == DIAG_IDLE);
	endsequence

	sequence sReadDiag;
		regRead && selDiag;
	endsequence

	sequence sReadSpecial;
		regRead && selSpecial;
	endsequence

	chk_start_launch: assert property (
		sStartWrite |=> cableTestStart && (diagState_reg == DIAG_RUN))
		else $error("cable test start not launched");

	chk_diag_selfclear: assert property (
		(diagState_reg == DIAG_RUN) && diagIn.done |=>
			(diagState_reg == DIAG_IDLE) && !cableTestStart)
		else $error("cable test bit did not self clear");

	chk_busy_readback: assert property (
		sReadDiag |=> regRdata[`PPCSB_DIAG_START] ==
			($past(diagState_reg) == DIAG_RUN))
		else $error("start bit readback wrong");

	chk_result_capture: assert property (
		(diagState_reg == DIAG_RUN) && diagIn.done ##1 sReadDiag |=>
			regRdata[`PPCSB_DIAG_RES_HI:`PPCSB_DIAG_RES_LO] ==
			$past(diagIn.result, 2))
		else $error("diagnostic outcome not reported");

	chk_near_short: assert property (
		sReadDiag |=> regRdata[`PPCSB_DIAG_NEAR] == $past(nearShort_reg))
		else $error("near short flag readback wrong");

	chk_fault_count: assert property (
		(diagState_reg == DIAG_RUN) && diagIn.done ##1 sReadDiag |=>
			regRdata[`PPCSB_DIAG_CNT_HI:`PPCSB_DIAG_CNT_LO] ==
			$past(diagIn.faultCount, 2))
		else $error("fault count not reported");

	chk_polarity_status: assert property (
		sReadSpecial |=> regRdata[`PPCSB_SPC_POL] ==
			$past(phyStatus.polarityReversed))
		else $error("polarity status wrong");

	chk_crossover_status: assert property (
		sReadSpecial |=> regRdata[`PPCSB_SPC_XOVER] ==
			$past(phyStatus.crossoverState))
		else $error("crossover status wrong");

	chk_force_link: assert property (
		forceLink_reg |=> phyCtrl.linkPass)
		else $error("forced link did not pass");

	chk_powersave_sense: assert property (
		wrSpecial |=> ##1 phyCtrl.powerSaveDisable ==
			$past(regWdata[`PPCSB_SPC_PWR], 2))
		else $error("power saving control wrong");

	chk_loopback_ctrl: assert property (
		wrSpecial |=> ##1 phyCtrl.remoteLoopback ==
			$past(regWdata[`PPCSB_SPC_RLB], 2))
		else $error("loopback control wrong");

	chk_storm_enable: assert property (
		wrPort1 |=> ##1 stormProtectEn == $past(regWdata[`PPCSB_P1_STORM], 2))
		else $error("storm protection enable wrong");

	chk_default_queue: assert property (
		ingressIn.valid && !dscpUse && !dot1pUse |=>
			classOut.valid && classOut.queue == $past(portPrio_reg))
		else $error("default priority not applied");

	chk_or_override: assert property (
		ingressIn.valid && (dscpUse || dot1pUse) |=>
			classOut.queue == ($past(dscpPart) | $past(dot1pPart)))
		else $error("classified priority wrong");

	chk_tag_insert: assert property (
		egressIn.valid |=> egressOut.addTag ==
			($past(tagIns_reg) && !$past(egressIn.arrivedTagged)))
		else $error("tag insertion decision wrong");

	chk_tag_remove: assert property (
		egressIn.valid |=> egressOut.stripTag ==
			($past(tagRm_reg) && $past(egressIn.arrivedTagged)))
		else $error("tag removal decision wrong");

	chk_reserved_zero: assert property (
		sReadSpecial |=> regRdata[15:6] == '0 && !regRdata[0])
		else $error("reserved bits not zero");

endmodule // ppcsb_bank

`default_nettype wire

/* File: ppcsb_bank_tb_top.sv */
// Self-checking bench for the port/PHY register bank.
// Assumes the bank's package and constants header are compiled alongside.
`default_nettype none

`include "ppcsb_consts.svh"

module ppcsb_bank_tb_top import ppcsb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic refClk, resetN, regWrite, regRead;
	logic [3:0] regAddr;
	logic [15:0] regWdata, regRdata, rdData;
	logic cableTestStart, stormProtectEn, multiQueueEn;
	ppcsb_diag_s diagIn;
	ppcsb_phy_status_s phyStatus;
	ppcsb_phy_ctrl_s phyCtrl;
	ppcsb_ingress_s ingressIn;
	ppcsb_class_s classOut;
	ppcsb_egress_s egressIn;
	ppcsb_egress_act_s egressOut;
	int nFail, numChecks, startCount;

	ppcsb_bank u_dut (.ref_clk(refClk), .reset_n(resetN),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata),
		.cableTestStart(cableTestStart), .diagIn(diagIn),
		.phyStatus(phyStatus), .phyCtrl(phyCtrl),
		.stormProtectEn(stormProtectEn), .multiQueueEn(multiQueueEn),
		.ingressIn(ingressIn), .classOut(classOut),
		.egressIn(egressIn), .egressOut(egressOut));

	initial begin
		refClk = 1'h0;
		forever #50 refClk = ~refClk;
	end

	// Start pulses are counted so a stretched pulse shows up as extra
	always @(posedge refClk) begin
		if (cableTestStart === 1'h1) startCount++;
	end

	// ---------------------------------------------------------------
	// Compare and bus tasks
	// ---------------------------------------------------------------
	task automatic chk16(input logic [15:0] got, exp, input string what);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("BAD at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, exp, input string what);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("BAD at %0t: %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic chk2(input logic [1:0] got, exp, input string what);
		numChecks++;
		if (got !== exp) begin
			nFail++;
			$display("BAD at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge refClk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'h1;
		@(posedge refClk);
		regWrite <= 1'h0;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [15:0] e,
		input string what);
		@(posedge refClk);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge refClk);
		regRead <= 1'h0;
		@(negedge refClk);
		chk16(regRdata, e, what);
	endtask

	// Registered controls lag a write by one extra cycle
	task automatic settle();
		repeat (2) @(negedge refClk);
	endtask

	task automatic endSim();
		$display("checks %0d failures %0d", numChecks, nFail);
		if (nFail == 0 && numChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic test_reset();
		rdchk(`PPCSB_OFS_PORT1_CTRL, 16'h0000, "port1 reset");
		@(negedge refClk);
		chk16(regRdata, 16'h0000, "rdata after read");
		rdchk(`PPCSB_OFS_CABLE_DIAG, 16'h0000, "diag reset");
		rdchk(`PPCSB_OFS_PHY_SPECIAL, 16'h0004, "special reset");
		chk1(phyCtrl.powerSaveDisable, 1'h1, "pwr out reset");
		rdchk(4'h2, 16'h0000, "unmapped read");
		$display("test reset done");
	endtask

	task automatic test_special();
		@(posedge refClk);
		phyStatus <= 3'h4;
		wr(`PPCSB_OFS_PHY_SPECIAL, 16'hffff);
		settle();
		chk1(phyCtrl.linkPass, 1'h1, "forced link");
		chk1(phyCtrl.remoteLoopback, 1'h1, "loopback on");
		chk1(phyCtrl.powerSaveDisable, 1'h1, "pwr off");
		rdchk(`PPCSB_OFS_PHY_SPECIAL, 16'h002e, "special ff");
		@(posedge refClk);
		phyStatus <= 3'h2;
		rdchk(`PPCSB_OFS_PHY_SPECIAL, 16'h001e, "mdi state");
		wr(`PPCSB_OFS_PHY_SPECIAL, 16'h0000);
		settle();
		chk1(phyCtrl.linkPass, 1'h0, "link follows detect");
		chk1(phyCtrl.powerSaveDisable, 1'h0, "pwr saving on");
		chk1(phyCtrl.remoteLoopback, 1'h0, "loopback off");
		@(posedge refClk);
		phyStatus <= 3'h1;
		settle();
		chk1(phyCtrl.linkPass, 1'h1, "detected link");
		rdchk(`PPCSB_OFS_PHY_SPECIAL, 16'h0000, "mdix state");
		wr(4'h2, 16'hffff);
		rdchk(`PPCSB_OFS_PHY_SPECIAL, 16'h0000, "unmapped write");
		rdchk(`PPCSB_OFS_PORT1_CTRL, 16'h0000, "unmapped write");
		$display("test special done");
	endtask

	task automatic test_ingress();
		logic [1:0] expQ;
		wr(`PPCSB_OFS_PORT1_CTRL, 16'hffff);
		settle();
		rdchk(`PPCSB_OFS_PORT1_CTRL, 16'h00ff, "port1 ff");
		chk1(stormProtectEn, 1'h1, "storm on");
		chk1(multiQueueEn, 1'h1, "multi queue on");
		for (int c = 0; c < 16; c++) begin
			wr(`PPCSB_OFS_PORT1_CTRL, {9'h0, c[1:0], c[3:2], 3'h0});
			settle();
			chk1(stormProtectEn, 1'h0, "storm off");
			chk1(multiQueueEn, 1'h0, "multi queue off");
			for (int h = 0; h < 4; h++) begin
				// DiffServ gives queue 1, 802.1p gives queue 2
				expQ = ((c[1] & h[1]) ? 2'h1 : 2'h0) |
					((c[0] & h[0]) ? 2'h2 : 2'h0);
				if (!((c[1] & h[1]) | (c[0] & h[0]))) expQ = c[3:2];
				@(posedge refClk);
				ingressIn <= {1'h1, h[1], 2'h1, h[0], 2'h2};
				@(posedge refClk);
				ingressIn <= '0;
				@(negedge refClk);
				chk1(classOut.valid, 1'h1, "class valid");
				chk2(classOut.queue, expQ, "queue");
			end
		end
		$display("test ingress done");
	endtask

	task automatic test_egress();
		for (int t = 0; t < 4; t++) begin
			wr(`PPCSB_OFS_PORT1_CTRL, {13'h0, t[1:0], 1'h0});
			settle();
			for (int g = 0; g < 2; g++) begin
				@(posedge refClk);
				egressIn <= {1'h1, g[0]};
				@(posedge refClk);
				egressIn <= '0;
				@(negedge refClk);
				chk1(egressOut.valid, 1'h1, "egress valid");
				chk1(egressOut.addTag, t[1] & !g[0], "add tag");
				chk1(egressOut.stripTag, t[0] & g[0], "strip tag");
			end
		end
		$display("test egress done");
	endtask

	// Reads the diagnostic register in the cycle right after done
	task automatic pulse_done(input logic [1:0] r, input logic n,
		input logic [8:0] k, input logic [15:0] e, input string what);
		@(posedge refClk);
		diagIn <= {1'h1, r, n, k};
		@(posedge refClk);
		// Fields scrambled after done so only latched values pass
		diagIn <= {1'h0, ~r, ~n, ~k};
		regAddr <= `PPCSB_OFS_CABLE_DIAG;
		regRead <= 1'h1;
		@(posedge refClk);
		regRead <= 1'h0;
		@(negedge refClk);
		chk16(regRdata, e, what);
	endtask

	task automatic test_cable();
		int s0;
		logic [8:0] k;
		logic [15:0] prevDiag;
		s0 = startCount;
		prevDiag = 16'h0000;
		wr(`PPCSB_OFS_CABLE_DIAG, 16'h7fff);
		settle();
		rdchk(`PPCSB_OFS_CABLE_DIAG, 16'h0000, "diag ro write");
		pulse_done(2'h3, 1'h1, 9'h1ff, 16'h0000, "idle done");
		chk16(16'(startCount - s0), 16'h0000, "no start");
		for (int r = 0; r < 4; r++) begin
			s0 = startCount;
			k = 9'h0a5 + 9'(r * 85);
			wr(`PPCSB_OFS_CABLE_DIAG, 16'h8000);
			settle();
			// Earlier results stay visible while the next test runs
			rdchk(`PPCSB_OFS_CABLE_DIAG, 16'h8000 | prevDiag, "busy");
			wr(`PPCSB_OFS_CABLE_DIAG, 16'h8000);
			settle();
			chk16(16'(startCount - s0), 16'h0001, "one start");
			prevDiag = {1'h0, r[1:0], r == 2, 3'h0, k};
			pulse_done(r[1:0], r == 2, k, prevDiag, "result");
		end
		$display("test cable done");
	endtask

	task automatic test_midreset();
		wr(`PPCSB_OFS_PHY_SPECIAL, 16'h000a);
		wr(`PPCSB_OFS_PORT1_CTRL, 16'h00ff);
		@(posedge refClk);
		resetN <= 1'h0;
		repeat (2) @(posedge refClk);
		resetN <= 1'h1;
		chk1(phyCtrl.powerSaveDisable, 1'h1, "pwr out in reset");
		rdchk(`PPCSB_OFS_PHY_SPECIAL, 16'h0004, "special re-reset");
		rdchk(`PPCSB_OFS_PORT1_CTRL, 16'h0000, "port1 re-reset");
		rdchk(`PPCSB_OFS_CABLE_DIAG, 16'h0000, "diag re-reset");
		chk1(stormProtectEn, 1'h0, "storm re-reset");
		chk1(phyCtrl.remoteLoopback, 1'h0, "loop re-reset");
		$display("test midreset done");
	endtask

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		resetN = 1'h0;
		regAddr = '0;
		regWdata = '0;
		regWrite = 1'h0;
		regRead = 1'h0;
		diagIn = '0;
		phyStatus = '0;
		ingressIn = '0;
		egressIn = '0;
		nFail = 0;
		numChecks = 0;
		startCount = 0;
		repeat (4) @(posedge refClk);
		resetN <= 1'h1;
		test_reset();
		test_special();
		test_ingress();
		test_egress();
		test_cable();
		test_midreset();
		endSim();
	end

	// Whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge refClk);
		nFail++;
		$display("BAD at %0t: watchdog expired", $time);
		endSim();
	end

endmodule // ppcsb_bank_tb_top

`default_nettype wire
